// ==== verilog/hbrc_top.sv ====
// Purpose: holding brake release control with its two parameters
// Assumes: power stage and drive state come from logic on the same clock
// Notes:   brake applying is handled elsewhere; release drops when power goes off
`timescale 1ns/1ps
module hbrc_top #(
  parameter int unsigned MS_CYCLES = hbrc_pkg::CYCLES_PER_MS
) (
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire hbrc_pkg::hbrc_bus_req_t     bus_req,
  output hbrc_pkg::hbrc_bus_rsp_t          bus_rsp,
  input  wire logic                        power_active,
  input  wire hbrc_pkg::hbrc_drive_state_t drive_state,
  input  wire logic [15:0]                 base_delay_ms,
  output logic                             brake_release
);
  import hbrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic                 power_prev_reg,   power_prev_next;
  logic [15:0]          extra_reg,        extra_next;
  logic [15:0]          sel_reg,          sel_next;
  logic [16:0]          total_ms_reg,     total_ms_next;
  logic                 release_reg,      release_next;
  hbrc_bus_rsp_t        rsp_reg,          rsp_next;

  logic                 power_rise;
  logic                 hit_extra;
  logic                 hit_sel;
  logic                 extra_ok;
  logic                 sel_ok;
  logic                 manual_state;
  logic                 timer_done;

  ////////////////////////////////////////////////////////////////////////////
  // register port and parameters

  always_comb begin
    power_rise   = power_active && !power_prev_reg;
    hit_extra    = bus_req.addr == ADDR_EXTRA_DELAY;
    hit_sel      = bus_req.addr == ADDR_HANDLING_SEL;
    extra_ok     = !power_active && ($signed(bus_req.wdata) >= $signed(EXTRA_DELAY_RESET))
                   && ($signed(bus_req.wdata) <= $signed(EXTRA_DELAY_MAX));
    sel_ok       = bus_req.wdata <= SEL_MAX;
    manual_state = (drive_state == DS_SWITCH_ON_DISABLED) ||
                   (drive_state == DS_READY_TO_SWITCH_ON) ||
                   (drive_state == DS_FAULT);

    power_prev_next = power_active;
    extra_next      = extra_reg;
    sel_next        = sel_reg;
    rsp_next        = '0;

    if (bus_req.wr) begin
      rsp_next.ack = 1'b1;
      if (hit_extra) begin
        if (extra_ok) begin
          extra_next = bus_req.wdata;
        end else begin
          rsp_next.err = 1'b1;
        end
      end else if (hit_sel) begin
        if (sel_ok) begin
          sel_next = bus_req.wdata;
        end else begin
          rsp_next.err = 1'b1;
        end
      end else begin
        rsp_next.err = 1'b1;
      end
    end else if (bus_req.rd) begin
      rsp_next.ack = 1'b1;
      if (hit_extra) begin
        rsp_next.rdata = extra_reg;
      end else if (hit_sel) begin
        rsp_next.rdata = sel_reg;
      end else begin
        rsp_next.err = 1'b1;
      end
    end

    if (power_active) begin
      sel_next = SEL_AUTO;
    end

    total_ms_next     = power_rise ? (17'(base_delay_ms) + 17'(extra_reg)) : total_ms_reg;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      power_prev_reg   <= 1'b0;
      extra_reg        <= EXTRA_DELAY_RESET;
      sel_reg          <= SEL_RESET;
      total_ms_reg     <= '0;
      rsp_reg          <= '0;
    end else begin
      power_prev_reg   <= power_prev_next;
      extra_reg        <= extra_next;
      sel_reg          <= sel_next;
      total_ms_reg     <= total_ms_next;
      rsp_reg          <= rsp_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // release delay and brake output

  hbrc_ms_timer #(
    .MS_CYCLES (MS_CYCLES),
    .MS_W      (17)
  ) u_timer (
    .clock   (clock),
    .nrst    (nrst),
    .start   (power_rise),
    .stop    (!power_active),
    .load_ms (total_ms_next),
    .done    (timer_done)
  );

  always_comb begin
    if (power_active) begin
      release_next = timer_done;
    end else begin
      release_next = (sel_reg == SEL_MANUAL) && manual_state;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      release_reg <= 1'b0;
    end else begin
      release_reg <= release_next;
    end
  end

  assign brake_release = release_reg;
  assign bus_rsp       = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [31:0] since_rise_reg, since_rise_next;

  always_comb begin
    since_rise_next = since_rise_reg;
    if (power_rise) begin
      since_rise_next = 32'h00000001;
    end else if (power_active && (since_rise_reg != 32'hffffffff)) begin
      since_rise_next = since_rise_reg + 32'h00000001;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      since_rise_reg <= '0;
    end else begin
      since_rise_reg <= since_rise_next;
    end
  end

  property p_total_delay;
    @(posedge clock) disable iff (!nrst)
      power_rise |=> total_ms_reg == (17'($past(base_delay_ms)) + 17'($past(extra_reg)));
  endproperty
  a_total_delay: assert property (p_total_delay) else $error("total delay not base plus extra");

  property p_extra_range;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && hit_extra && ($signed(bus_req.wdata) > $signed(EXTRA_DELAY_MAX))
      |=> bus_rsp.err && $stable(extra_reg);
  endproperty
  a_extra_range: assert property (p_extra_range) else $error("out of range extra delay taken");

  property p_extra_locked;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && hit_extra && power_active |=> bus_rsp.ack && bus_rsp.err && $stable(extra_reg);
  endproperty
  a_extra_locked: assert property (p_extra_locked) else $error("extra delay written while powered");

  property p_extra_taken;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && hit_extra && extra_ok |=> extra_reg == $past(bus_req.wdata) && !bus_rsp.err;
  endproperty
  a_extra_taken: assert property (p_extra_taken) else $error("valid extra delay write lost");

  property p_extra_deferred;
    @(posedge clock) disable iff (!nrst)
      !power_rise |=> $stable(total_ms_reg);
  endproperty
  a_extra_deferred: assert property (p_extra_deferred) else $error("extra delay used before enable");

  property p_sel_range;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && hit_sel && (bus_req.wdata > SEL_MAX) |=> bus_rsp.err && (sel_reg <= SEL_MAX);
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("handling select out of range");

  property p_manual_states;
    @(posedge clock) disable iff (!nrst)
      brake_release && !$past(power_active) |-> $past(manual_state) && $past(sel_reg) == SEL_MANUAL;
  endproperty
  a_manual_states: assert property (p_manual_states) else $error("manual release in wrong state");

  property p_sel_forced;
    @(posedge clock) disable iff (!nrst)
      power_active |=> sel_reg == SEL_AUTO;
  endproperty
  a_sel_forced: assert property (p_sel_forced) else $error("select not cleared while powered");

  property p_sel_immediate;
    @(posedge clock) disable iff (!nrst)
      bus_req.wr && hit_sel && sel_ok && !power_active && manual_state && bus_req.wdata == SEL_MANUAL
      |=> sel_reg == SEL_MANUAL ##1 brake_release;
  endproperty
  a_sel_immediate: assert property (p_sel_immediate) else $error("manual release not immediate");

  property p_auto_timing;
    @(posedge clock) disable iff (!nrst)
      $rose(brake_release) && $past(power_active)
      |-> $past(since_rise_reg) == (32'(total_ms_reg) * 32'(MS_CYCLES) + 32'h00000001);
  endproperty
  a_auto_timing: assert property (p_auto_timing) else $error("automatic release at wrong time");

  property p_unmapped;
    @(posedge clock) disable iff (!nrst)
      (bus_req.wr || bus_req.rd) && !hit_extra && !hit_sel |=> bus_rsp.ack && bus_rsp.err;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  c_manual: cover property (@(posedge clock) disable iff (!nrst) brake_release && !power_active);
  c_auto: cover property (@(posedge clock) disable iff (!nrst) $rose(brake_release) && power_active);
  c_reject: cover property (@(posedge clock) disable iff (!nrst) bus_req.wr && hit_extra && power_active);
  c_forced: cover property (@(posedge clock) disable iff (!nrst) sel_reg == SEL_MANUAL ##1 power_active);
endmodule

// ==== verilog/hbrc_pkg.sv ====
// Purpose: constants and carriers for the holding brake release control
// Assumes: 50 MHz system clock, parameter port on the drive's own clock
// Notes:   delays are in milliseconds; register values are 16 bits wide
package hbrc_pkg;

  localparam int unsigned CLOCK_HZ          = 50000000;
  localparam int unsigned MS_PER_S          = 1000;
  localparam int unsigned CYCLES_PER_MS     = CLOCK_HZ / MS_PER_S;

  localparam logic [15:0] ADDR_EXTRA_DELAY  = 16'h050e;
  localparam logic [15:0] ADDR_HANDLING_SEL = 16'h0814;

  localparam logic [15:0] EXTRA_DELAY_RESET = 16'h0000;
  localparam logic [15:0] EXTRA_DELAY_MAX   = 16'h0190;
  localparam logic [15:0] SEL_RESET         = 16'h0000;
  localparam logic [15:0] SEL_AUTO          = 16'h0000;
  localparam logic [15:0] SEL_MANUAL        = 16'h0001;
  localparam logic [15:0] SEL_MAX           = 16'h0001;

  typedef enum logic [2:0] {
    DS_NOT_READY,
    DS_SWITCH_ON_DISABLED,
    DS_READY_TO_SWITCH_ON,
    DS_SWITCHED_ON,
    DS_OPERATION_ENABLED,
    DS_QUICK_STOP,
    DS_FAULT_REACTION,
    DS_FAULT
  } hbrc_drive_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hbrc_bus_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } hbrc_bus_rsp_t;

endpackage

// ==== verilog/hbrc_ms_timer.sv ====
// Purpose: millisecond down counter for the release delay
// Assumes: start and stop come from logic on the same clock
// Notes:   done rises on the same edge that ends the last millisecond
`timescale 1ns/1ps
module hbrc_ms_timer #(
  parameter int unsigned MS_CYCLES = hbrc_pkg::CYCLES_PER_MS,
  parameter int unsigned MS_W      = 17
) (
  input  wire logic            clock,
  input  wire logic            nrst,
  input  wire logic            start,
  input  wire logic            stop,
  input  wire logic [MS_W-1:0] load_ms,
  output logic                 done
);
  localparam int unsigned CW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [CW-1:0] CYC_LAST = CW'(MS_CYCLES - 1);

  logic            run_reg,  run_next;
  logic [MS_W-1:0] ms_reg,   ms_next;
  logic [CW-1:0]   cyc_reg,  cyc_next;
  logic            done_reg, done_next;

  always_comb begin
    run_next = run_reg;
    ms_next  = ms_reg;
    cyc_next = cyc_reg;
    if (stop) begin
      run_next = 1'b0;
      cyc_next = '0;
    end else if (start) begin
      run_next = 1'b1;
      ms_next  = load_ms;
      cyc_next = '0;
    end else if (run_reg && (ms_reg != '0)) begin
      if (cyc_reg == CYC_LAST) begin
        cyc_next = '0;
        ms_next  = ms_reg - MS_W'(1);
      end else begin
        cyc_next = cyc_reg + CW'(1);
      end
    end
    done_next = run_next && (ms_next == '0);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_reg  <= 1'b0;
      ms_reg   <= '0;
      cyc_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      run_reg  <= run_next;
      ms_reg   <= ms_next;
      cyc_reg  <= cyc_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule

// ==== sim/hbrc_brake_model.sv ====
// Purpose: motor holding brake with its electronic nameplate
// Assumes: release level comes from the drive on the same clock
// Notes:   nameplate delay is changed by the bench before and during each run
`timescale 1ns/1ps
module hbrc_brake_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        brake_release,
  output logic      [15:0] base_delay_ms,
  output logic             brake_open
);
  logic [15:0] base_ms = 16'h0001;
  assign base_delay_ms = base_ms;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) brake_open <= 1'b0;
    else brake_open <= brake_release;
  end
endmodule

// ==== sim/tb_holding_brake_release_control.sv ====
// Purpose: self-checking bench for the brake release control
// Assumes: inputs driven at the falling edge
// Notes:   short millisecond so delays stay brief
`timescale 1ns/1ps
module tb_holding_brake_release_control;
  import hbrc_pkg::*;
  localparam int MSC = 4;
  logic              clock = 1'b0;
  logic              nrst = 1'b0;
  hbrc_bus_req_t     bus_req = '0;
  hbrc_bus_rsp_t     bus_rsp;
  logic              power_active = 1'b0;
  hbrc_drive_state_t drive_state = DS_SWITCH_ON_DISABLED;
  logic [15:0]       base_delay_ms;
  logic              brake_release;
  logic              brake_open;
  int                n_fail = 0;
  int                total_checks = 0;
  always #10 clock = ~clock;
  hbrc_top #(.MS_CYCLES(MSC)) dut (
    .clock(clock), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp), .power_active(power_active),
    .drive_state(drive_state), .base_delay_ms(base_delay_ms), .brake_release(brake_release)
  );
  hbrc_brake_model brake (
    .clock(clock), .nrst(nrst), .brake_release(brake_release),
    .base_delay_ms(base_delay_ms), .brake_open(brake_open)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e,
                     input logic [15:0] rd);
    bus_req.wr = w;
    bus_req.rd = !w;
    bus_req.addr = a;
    bus_req.wdata = d;
    @(posedge clock);
    @(negedge clock);
    bus_req = '0;
    chk({15'h0000, bus_rsp.ack}, 16'h0001);
    chk({15'h0000, bus_rsp.err}, {15'h0000, e});
    if (!w && !e) chk(bus_rsp.rdata, rd);
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    acc(1'b0, ADDR_EXTRA_DELAY, 16'h0000, 1'b0, EXTRA_DELAY_RESET);
    acc(1'b0, ADDR_HANDLING_SEL, 16'h0000, 1'b0, SEL_RESET);
    acc(1'b0, 16'h0001, 16'h0000, 1'b1, 16'h0000);
    acc(1'b1, 16'h0815, 16'h0001, 1'b1, 16'h0000);
    chk({15'h0000, brake_release}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_extra;
    acc(1'b1, ADDR_EXTRA_DELAY, EXTRA_DELAY_MAX, 1'b0, 16'h0000);
    acc(1'b1, ADDR_EXTRA_DELAY, 16'h0191, 1'b1, 16'h0000);
    acc(1'b1, ADDR_EXTRA_DELAY, 16'hffff, 1'b1, 16'h0000);
    acc(1'b0, ADDR_EXTRA_DELAY, 16'h0000, 1'b0, 16'h0190);
    power_active = 1'b1;
    acc(1'b1, ADDR_EXTRA_DELAY, 16'h0005, 1'b1, 16'h0000);
    power_active = 1'b0;
    acc(1'b0, ADDR_EXTRA_DELAY, 16'h0000, 1'b0, 16'h0190);
    step(1);
    $display("test extra delay done");
  endtask
  task automatic t_manual;
    acc(1'b1, ADDR_HANDLING_SEL, 16'h0002, 1'b1, 16'h0000);
    acc(1'b1, ADDR_HANDLING_SEL, SEL_MANUAL, 1'b0, 16'h0000);
    step(1);
    chk({15'h0000, brake_release}, 16'h0001);
    for (int s = 0; s < 8; s++) begin
      drive_state = hbrc_drive_state_t'(s);
      step(1);
      chk({15'h0000, brake_release}, {15'h0000, (s == 1 || s == 2 || s == 7)});
    end
    $display("test manual done");
  endtask
  task automatic t_force;
    power_active = 1'b1;
    step(1);
    power_active = 1'b0;
    acc(1'b0, ADDR_HANDLING_SEL, 16'h0000, 1'b0, SEL_AUTO);
    step(1);
    chk({15'h0000, brake_release}, 16'h0000);
    power_active = 1'b1;
    acc(1'b1, ADDR_HANDLING_SEL, SEL_MANUAL, 1'b0, 16'h0000);
    acc(1'b0, ADDR_HANDLING_SEL, 16'h0000, 1'b0, SEL_AUTO);
    power_active = 1'b0;
    step(2);
    $display("test forced select done");
  endtask
  task automatic t_auto(input logic [15:0] base, input logic [15:0] extra);
    int n;
    n = (int'(base) + int'(extra)) * MSC + 2;
    brake.base_ms = base;
    acc(1'b1, ADDR_EXTRA_DELAY, extra, 1'b0, 16'h0000);
    power_active = 1'b1;
    step(1);
    brake.base_ms = 16'h0009;
    step(n - 2);
    chk({15'h0000, brake_release}, 16'h0000);
    step(1);
    chk({15'h0000, brake_release}, 16'h0001);
    step(3);
    chk({15'h0000, brake_release}, 16'h0001);
    chk({15'h0000, brake_open}, 16'h0001);
    power_active = 1'b0;
    step(2);
    chk({15'h0000, brake_release}, 16'h0000);
    $display("test automatic release done");
  endtask
  task automatic t_rst;
    acc(1'b1, ADDR_EXTRA_DELAY, 16'h0005, 1'b0, 16'h0000);
    acc(1'b1, ADDR_HANDLING_SEL, SEL_MANUAL, 1'b0, 16'h0000);
    chk({15'h0000, brake_release}, 16'h0001);
    nrst = 1'b0;
    step(2);
    chk({15'h0000, brake_release}, 16'h0000);
    nrst = 1'b1;
    acc(1'b0, ADDR_EXTRA_DELAY, 16'h0000, 1'b0, EXTRA_DELAY_RESET);
    acc(1'b0, ADDR_HANDLING_SEL, 16'h0000, 1'b0, SEL_RESET);
    chk({15'h0000, brake_release}, 16'h0000);
    $display("test mid-run reset done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    step(5);
    nrst = 1'b1;
    t_reset;
    t_extra;
    t_manual;
    t_force;
    t_auto(16'h0001, 16'h0002);
    t_auto(16'h0002, 16'h0000);
    t_rst;
    give_verdict;
  end
  initial begin
    #1000000;
    n_fail++;
    give_verdict;
  end
endmodule
